//--- src/rfr_responder.sv
// rtu slave: character parity, frame crc, gap timing and read-words answer
`timescale 1ns/1ns
module rfr_responder
   import rfr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // serial line toward the rs485 transceiver
   input wire logic rxd,
   output logic txd,
   output logic txEnable,
   // configuration
   input wire logic [7:0] stationAddr,
   input rfr_parity_t parityMode,
   input wire logic dataBits8,
   input wire logic [15:0] bitCycles,
   // word read port, data taken combinationally in the same cycle as the address
   output logic [15:0] wordAddr,
   input wire logic [15:0] wordData,
   // status pulses
   output logic parityErr,
   output logic crcErr,
   output logic frameAccepted
);
`include "rfr_defs.svh"

   // one crc byte step, shared by receive check and transmit generation
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `RFR_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crcByte

   // parity bit for the configured data width and sense
   function automatic logic parityBit(input logic [7:0] b, input logic eight,
                                      input rfr_parity_t mode);
      logic ones;
      ones = ^(eight ? b : {1'b0, b[6:0]});
      return (mode == RFR_PAR_ODD) ? ~ones : ones;
   endfunction : parityBit

   rfr_rx_t rxState;
   rfr_tx_t txState;
   rfr_gen_t genState;
   logic [15:0] bitLast;
   logic [15:0] halfLast;
   logic [15:0] rxCnt;
   logic [3:0] rxBits;
   logic [3:0] dataCount;
   logic [7:0] rxShift;
   logic [7:0] rxByte;
   logic rxByteStb;
   logic rxParBad;
   logic rxStopBad;
   logic [15:0] hbCnt;
   logic hbTick;
   logic [7:0] gapCnt;
   logic [3:0] charBits;
   logic [7:0] shortLimit;
   logic [7:0] longLimit;
   logic lineIdle;
   logic shortEdge;
   logic longEdge;
   logic frameOpen;
   logic frameBad;
   logic [4:0] byteCnt;
   logic [7:0] reqByte [0:5];
   logic [7:0] lastByte;
   logic [7:0] prevByte;
   logic [15:0] crcRun;
   logic [15:0] crcLag1;
   logic [15:0] crcLag2;
   logic frameClose;
   logic crcGood;
   logic [15:0] reqCount;
   logic countOk;
   logic forUs;
   logic readOk;
   logic respPending;
   logic [15:0] respAddr;
   logic [4:0] respWords;
   logic genStart;
   logic [4:0] wordsLeft;
   logic [15:0] crcTx;
   logic [7:0] genByte;
   logic genPush;
   logic [15:0] txCnt;
   logic [3:0] txIdx;
   logic [7:0] txByte;
   logic [7:0] txShift;
   logic stopLeft;
   logic txTake;

   rfr_byte_if genToBuf ();
   rfr_byte_if bufToTx ();

   rfr_byte_buf respBuf (
      .clock(clock),
      .resetn(resetn),
      .fill(genToBuf.consumer),
      .drain(bufToTx.producer)
   );

   // bit timing derived from the configured bit period
   assign bitLast = bitCycles - 16'h0001;
   assign halfLast = {1'b0, bitCycles[15:1]} - 16'h0001;
   assign dataCount = dataBits8 ? 4'h8 : 4'h7;
   assign charBits = dataCount + `RFR_CHAR_OVERHEAD;
   assign rxByte = dataBits8 ? rxShift : {1'b0, rxShift[7:1]};

   // receive character engine; own echo is ignored while driving the line
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rxState <= RFR_RX_IDLE;
         rxCnt <= 16'h0000;
         rxBits <= 4'h0;
         rxShift <= 8'h00;
         rxByteStb <= 1'b0;
         rxParBad <= 1'b0;
         rxStopBad <= 1'b0;
      end else begin
         rxByteStb <= 1'b0;
         if (txEnable) begin
            rxState <= RFR_RX_IDLE;
         end else begin
            unique case (rxState)
               RFR_RX_IDLE: begin
                  rxCnt <= 16'h0000;
                  if (!rxd) rxState <= RFR_RX_START;
               end
               RFR_RX_START: begin
                  rxCnt <= rxCnt + 16'h0001;
                  if (rxCnt == halfLast) begin
                     rxCnt <= 16'h0000;
                     rxBits <= 4'h0;
                     rxState <= rxd ? RFR_RX_IDLE : RFR_RX_DATA; // glitch rejected
                  end
               end
               RFR_RX_DATA: begin
                  rxCnt <= rxCnt + 16'h0001;
                  if (rxCnt == bitLast) begin
                     rxCnt <= 16'h0000;
                     rxShift <= {rxd, rxShift[7:1]};
                     rxBits <= rxBits + 4'h1;
                     rxParBad <= 1'b0;
                     if (rxBits + 4'h1 == dataCount) begin
                        rxState <= (parityMode == RFR_PAR_NONE) ? RFR_RX_STOP : RFR_RX_PAR;
                     end
                  end
               end
               RFR_RX_PAR: begin
                  rxCnt <= rxCnt + 16'h0001;
                  if (rxCnt == bitLast) begin
                     rxCnt <= 16'h0000;
                     rxParBad <= (rxd != parityBit(rxByte, dataBits8, parityMode));
                     rxState <= RFR_RX_STOP;
                  end
               end
               RFR_RX_STOP: begin
                  rxCnt <= rxCnt + 16'h0001;
                  if (rxCnt == bitLast) begin
                     rxStopBad <= !rxd;
                     rxByteStb <= 1'b1;
                     rxState <= RFR_RX_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // half-bit enable pulse from a free-running divider
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hbCnt <= 16'h0000;
      end else begin
         hbCnt <= hbTick ? 16'h0000 : hbCnt + 16'h0001;
      end
   end
   assign hbTick = (hbCnt >= halfLast);

   // line silence measured in half-bits; starts saturated so the first frame counts
   assign lineIdle = (rxState == RFR_RX_IDLE) && !txEnable && rxd;
   assign shortLimit = {4'h0, charBits} * `RFR_GAP_ABORT_HALFCHARS;
   assign longLimit = {4'h0, charBits} * `RFR_GAP_FRAME_HALFCHARS;
   assign shortEdge = lineIdle && hbTick && (gapCnt + 8'h01 == shortLimit);
   assign longEdge = lineIdle && hbTick && (gapCnt + 8'h01 == longLimit);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gapCnt <= `RFR_GAP_RESET;
      end else if (!lineIdle) begin
         gapCnt <= 8'h00;
      end else if (hbTick && gapCnt != `RFR_GAP_RESET) begin
         gapCnt <= gapCnt + 8'h01;
      end
   end

   // frame assembly and running crc over received bytes
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         frameOpen <= 1'b0;
         frameBad <= 1'b0;
         byteCnt <= 5'h00;
         lastByte <= 8'h00;
         prevByte <= 8'h00;
         crcRun <= `RFR_CRC_INIT;
         crcLag1 <= `RFR_CRC_INIT;
         crcLag2 <= `RFR_CRC_INIT;
         for (int i = 0; i < 6; i++) reqByte[i] <= 8'h00;
      end else if (rxByteStb) begin
         frameOpen <= 1'b1;
         prevByte <= lastByte;
         lastByte <= rxByte;
         if (byteCnt < 5'h06 || !frameOpen) reqByte[frameOpen ? byteCnt[2:0] : 3'h0] <= rxByte;
         if (!frameOpen) begin
            byteCnt <= 5'h01;
            frameBad <= rxParBad || rxStopBad;
            crcRun <= crcByte(`RFR_CRC_INIT, rxByte);
            crcLag1 <= `RFR_CRC_INIT;
            crcLag2 <= `RFR_CRC_INIT;
         end else begin
            if (byteCnt != 5'h1f) byteCnt <= byteCnt + 5'h01;
            frameBad <= frameBad || rxParBad || rxStopBad;
            crcRun <= crcByte(crcRun, rxByte);
            crcLag1 <= crcRun;
            crcLag2 <= crcLag1; // crc over all but the last two bytes
         end
      end else if (shortEdge) begin
         frameOpen <= 1'b0;
      end
   end

   // frame verdict at the 1.5 character silence
   assign frameClose = shortEdge && frameOpen;
   assign crcGood = (crcLag2 == {lastByte, prevByte});
   assign reqCount = {reqByte[4], reqByte[5]};
   assign countOk = (reqCount != 16'h0000) && (reqCount <= `RFR_MAX_WORDS);
   assign forUs = (reqByte[0] == stationAddr) || (reqByte[0] == `RFR_ADDR_BCAST);
   assign readOk = !frameBad && crcGood && (byteCnt == `RFR_REQ_LEN)
      && (reqByte[0] == stationAddr) && (reqByte[0] != `RFR_ADDR_BCAST)
      && (reqByte[1] == `RFR_FUNC_READ) && countOk;

   // status pulses
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         parityErr <= 1'b0;
         crcErr <= 1'b0;
         frameAccepted <= 1'b0;
      end else begin
         parityErr <= rxByteStb && rxParBad;
         crcErr <= frameClose && byteCnt >= `RFR_MIN_CHECKED_LEN && !crcGood;
         frameAccepted <= frameClose && !frameBad && crcGood && forUs
            && byteCnt >= `RFR_MIN_CHECKED_LEN;
      end
   end

   // pending answer waits for the full inter-frame gap; a new byte cancels it
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         respPending <= 1'b0;
         respAddr <= 16'h0000;
         respWords <= 5'h00;
      end else if (frameClose) begin
         respPending <= readOk;
         respAddr <= {reqByte[2], reqByte[3]};
         respWords <= reqCount[4:0];
      end else if (rxByteStb || genStart) begin
         respPending <= 1'b0;
      end
   end
   assign genStart = longEdge && respPending && genState == RFR_GEN_IDLE;

   // response byte selection
   always_comb begin
      unique case (genState)
         RFR_GEN_IDLE: genByte = 8'h00;
         RFR_GEN_ADDR: genByte = stationAddr;
         RFR_GEN_FUNC: genByte = `RFR_FUNC_READ;
         RFR_GEN_CNT: genByte = {2'h0, respWords, 1'b0};
         RFR_GEN_HI: genByte = wordData[15:8];
         RFR_GEN_LO: genByte = wordData[7:0];
         RFR_GEN_CRCL: genByte = crcTx[7:0];
         RFR_GEN_CRCH: genByte = crcTx[15:8];
      endcase
   end
   assign genToBuf.data = genByte;
   assign genToBuf.valid = (genState != RFR_GEN_IDLE);
   assign genPush = genToBuf.valid && genToBuf.ready;

   // response generator; stalls while the buffer is full
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         genState <= RFR_GEN_IDLE;
         wordsLeft <= 5'h00;
         wordAddr <= 16'h0000;
         crcTx <= `RFR_CRC_INIT;
      end else if (genStart) begin
         genState <= RFR_GEN_ADDR;
         wordsLeft <= respWords;
         wordAddr <= respAddr;
         crcTx <= `RFR_CRC_INIT;
      end else if (genPush) begin
         if (genState != RFR_GEN_CRCL && genState != RFR_GEN_CRCH) begin
            crcTx <= crcByte(crcTx, genByte);
         end
         unique case (genState)
            RFR_GEN_IDLE: genState <= RFR_GEN_IDLE;
            RFR_GEN_ADDR: genState <= RFR_GEN_FUNC;
            RFR_GEN_FUNC: genState <= RFR_GEN_CNT;
            RFR_GEN_CNT: genState <= RFR_GEN_HI;
            RFR_GEN_HI: genState <= RFR_GEN_LO;
            RFR_GEN_LO: begin
               wordAddr <= wordAddr + 16'h0001;
               wordsLeft <= wordsLeft - 5'h01;
               genState <= (wordsLeft == 5'h01) ? RFR_GEN_CRCL : RFR_GEN_HI;
            end
            RFR_GEN_CRCL: genState <= RFR_GEN_CRCH;
            RFR_GEN_CRCH: genState <= RFR_GEN_IDLE;
         endcase
      end
   end

   // serializer pulls a byte only when the line is free
   assign txTake = (txState == RFR_TX_IDLE);
   assign bufToTx.ready = txTake;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         txState <= RFR_TX_IDLE;
         txCnt <= 16'h0000;
         txIdx <= 4'h0;
         txByte <= 8'h00;
         txShift <= 8'h00;
         stopLeft <= 1'b0;
         txd <= 1'b1;
      end else begin
         txCnt <= (txCnt == bitLast) ? 16'h0000 : txCnt + 16'h0001;
         unique case (txState)
            RFR_TX_IDLE: begin
               txd <= 1'b1;
               txCnt <= 16'h0000;
               if (bufToTx.valid) begin
                  txByte <= bufToTx.data;
                  txShift <= bufToTx.data;
                  txd <= 1'b0; // start bit
                  txState <= RFR_TX_START;
               end
            end
            RFR_TX_START, RFR_TX_DATA: if (txCnt == bitLast) begin
               if (txState == RFR_TX_DATA && txIdx == dataCount) begin
                  if (parityMode == RFR_PAR_NONE) begin
                     txd <= 1'b1;
                     stopLeft <= 1'b1;
                     txState <= RFR_TX_STOP;
                  end else begin
                     txd <= parityBit(txByte, dataBits8, parityMode);
                     txState <= RFR_TX_PAR;
                  end
               end else begin
                  txd <= txShift[0];
                  txShift <= txShift >> 1;
                  txIdx <= (txState == RFR_TX_START) ? 4'h1 : txIdx + 4'h1;
                  txState <= RFR_TX_DATA;
               end
            end
            RFR_TX_PAR: if (txCnt == bitLast) begin
               txd <= 1'b1;
               stopLeft <= 1'b0;
               txState <= RFR_TX_STOP;
            end
            RFR_TX_STOP: if (txCnt == bitLast) begin
               if (stopLeft) stopLeft <= 1'b0;
               else txState <= RFR_TX_IDLE;
            end
            default: txState <= RFR_TX_IDLE;
         endcase
      end
   end

   // driver enable covers the whole answer, released after the last stop bit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         txEnable <= 1'b0;
      end else begin
         txEnable <= genStart || genState != RFR_GEN_IDLE || bufToTx.valid
            || txState != RFR_TX_IDLE;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_crc_low_sent;
      genState == RFR_GEN_CRCL && genPush;
   endsequence
   sequence s_crc_high_next;
      genState == RFR_GEN_CRCH && genByte == crcTx[15:8];
   endsequence

   a_crc_seed_new: assert property (rxByteStb && !frameOpen |=>
      crcRun == crcByte(`RFR_CRC_INIT, $past(rxByte)) && byteCnt == 5'h01)
      else $error("crc not seeded with all ones at frame start");
   a_tx_parity_bit: assert property (txState == RFR_TX_PAR && $past(txState) == RFR_TX_PAR
      |-> txd == parityBit(txByte, dataBits8, parityMode))
      else $error("transmitted parity bit wrong");
   a_no_parity_slot: assert property (parityMode == RFR_PAR_NONE |->
      txState != RFR_TX_PAR && rxState != RFR_RX_PAR)
      else $error("parity slot used with parity off");
   a_rx_parity_flag: assert property (rxByteStb && rxParBad |=> parityErr)
      else $error("parity mismatch not flagged");
   a_crc_err_flag: assert property (frameClose && byteCnt >= `RFR_MIN_CHECKED_LEN
      && crcLag2 != {lastByte, prevByte} |=> crcErr && !respPending)
      else $error("crc mismatch not flagged or answered");
   a_crc_order: assert property (s_crc_low_sent |=> s_crc_high_next)
      else $error("crc high byte does not follow low byte");
   a_byte_count: assert property (genState == RFR_GEN_CNT |->
      genByte == {2'h0, wordsLeft, 1'b0} && wordsLeft != 5'h00)
      else $error("byte count field not twice word count");
   a_word_step: assert property (genState == RFR_GEN_LO && genPush |=>
      wordAddr == $past(wordAddr) + 16'h0001)
      else $error("word address did not step up");
   a_bcast_silent: assert property (frameClose && reqByte[0] == `RFR_ADDR_BCAST
      |=> !respPending)
      else $error("broadcast frame queued an answer");
   a_start_after_gap: assert property ($rose(txEnable) |->
      $past(longEdge) && $past(respPending))
      else $error("driver enabled before the frame gap");
   a_bad_count: assert property (frameClose && !countOk |=> !respPending)
      else $error("bad word count queued an answer");
endmodule : rfr_responder

//--- src/rfr_defs.svh
// constants for the rtu frame check and read responder
`ifndef RFR_DEFS_SVH
`define RFR_DEFS_SVH
`define RFR_CRC_INIT 16'hffff
`define RFR_CRC_POLY 16'ha001
`define RFR_FUNC_READ 8'h03
`define RFR_ADDR_BCAST 8'h00
`define RFR_MAX_WORDS 16'h0010
`define RFR_REQ_LEN 5'h08
`define RFR_MIN_CHECKED_LEN 5'h03
`define RFR_CHAR_OVERHEAD 4'h3
`define RFR_GAP_ABORT_HALFCHARS 8'h03
`define RFR_GAP_FRAME_HALFCHARS 8'h07
`define RFR_GAP_RESET 8'hff
`define RFR_BUF_DEPTH 2'h2
`endif

//--- src/rfr_pkg.sv
// types shared by the responder and its output buffer
package rfr_pkg;
   typedef enum logic [1:0] {
      RFR_PAR_NONE = 2'h0,
      RFR_PAR_EVEN = 2'h1,
      RFR_PAR_ODD = 2'h2
   } rfr_parity_t;
   typedef enum logic [2:0] {
      RFR_RX_IDLE = 3'h0,
      RFR_RX_START = 3'h1,
      RFR_RX_DATA = 3'h3,
      RFR_RX_PAR = 3'h2,
      RFR_RX_STOP = 3'h6
   } rfr_rx_t;
   typedef enum logic [2:0] {
      RFR_TX_IDLE = 3'h0,
      RFR_TX_START = 3'h1,
      RFR_TX_DATA = 3'h3,
      RFR_TX_PAR = 3'h2,
      RFR_TX_STOP = 3'h6
   } rfr_tx_t;
   typedef enum logic [2:0] {
      RFR_GEN_IDLE = 3'h0,
      RFR_GEN_ADDR = 3'h1,
      RFR_GEN_FUNC = 3'h3,
      RFR_GEN_CNT = 3'h2,
      RFR_GEN_HI = 3'h6,
      RFR_GEN_LO = 3'h7,
      RFR_GEN_CRCL = 3'h5,
      RFR_GEN_CRCH = 3'h4
   } rfr_gen_t;
endpackage : rfr_pkg

//--- src/rfr_byte_if.sv
// byte stream with valid and ready between responder stages
`timescale 1ns/1ns
interface rfr_byte_if;
   logic [7:0] data;
   logic valid;
   logic ready;
   modport producer (output data, output valid, input ready);
   modport consumer (input data, input valid, output ready);
endinterface : rfr_byte_if

//--- src/rfr_byte_buf.sv
// two-entry byte buffer so a stalled serializer loses no response byte
`timescale 1ns/1ns
module rfr_byte_buf
   import rfr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // filling and draining sides
   rfr_byte_if.consumer fill,
   rfr_byte_if.producer drain
);
`include "rfr_defs.svh"

   logic [7:0] mem [0:1];
   logic wrPtr;
   logic rdPtr;
   logic [1:0] count;
   logic doWrite;
   logic doRead;

   assign doWrite = fill.valid && fill.ready;
   assign doRead = drain.valid && drain.ready;
   // full and empty straight from the occupancy count
   assign fill.ready = (count != `RFR_BUF_DEPTH);
   assign drain.valid = (count != 2'h0);
   assign drain.data = mem[rdPtr];

   // storage, written only while not full
   always_ff @(posedge clock) begin
      if (doWrite) begin
         mem[wrPtr] <= fill.data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (doWrite) wrPtr <= ~wrPtr;
         if (doRead) rdPtr <= ~rdPtr;
         count <= count + {1'b0, doWrite} - {1'b0, doRead};
      end
   end

   a_buf_no_overflow: assert property (@(posedge clock) disable iff (!resetn)
      count == `RFR_BUF_DEPTH && !doRead |=> count == `RFR_BUF_DEPTH && !fill.ready)
      else $error("buffer occupancy changed while full and stalled");
endmodule : rfr_byte_buf

//--- test/rfr_master_model.sv
// bus master model: sends request characters and decodes the answer
`timescale 1ns/1ns
module rfr_master_model
   import rfr_pkg::*;
(
   // clock
   input wire logic clock,
   // serial line; the answer counts only while the slave's driver is on
   input wire logic txd,
   input wire logic txEnable,
   output logic rxd,
   // character format
   input rfr_parity_t parityMode,
   input wire logic dataBits8,
   input wire logic [15:0] bitCycles,
   // decoded answer bytes
   output logic [7:0] gotByte,
   output logic gotStrobe,
   output logic gotParOk
);
   logic busLine;
   // a released line floats to idle high through the bias resistors
   assign busLine = txEnable ? txd : 1'b1;
   initial begin
      rxd = 1'b1;
      gotStrobe = 1'b0;
      gotByte = 8'h00;
      gotParOk = 1'b0;
   end
   function automatic logic parBit(input logic [7:0] b);
      logic ones;
      ones = ^(b & (dataBits8 ? 8'hff : 8'h7f));
      return (parityMode == RFR_PAR_ODD) ? ~ones : ones;
   endfunction : parBit
   // one character lsb first; flip forces a wrong parity bit
   task automatic sendChar(input logic [7:0] b, input logic flip);
      rxd <= 1'b0;
      repeat (bitCycles) @(posedge clock);
      for (int i = 0; i < (dataBits8 ? 8 : 7); i++) begin
         rxd <= b[i];
         repeat (bitCycles) @(posedge clock);
      end
      if (parityMode != RFR_PAR_NONE) begin
         rxd <= parBit(b) ^ flip;
         repeat (bitCycles) @(posedge clock);
      end
      // two stop bits cover both formats; one idle bit is far below the abort gap
      rxd <= 1'b1;
      repeat (2 * bitCycles) @(posedge clock);
   endtask : sendChar
   // decode the answer at mid-bit after each falling start edge
   always begin : decode
      logic [7:0] b;
      logic p;
      @(negedge busLine);
      b = 8'h00;
      repeat (bitCycles / 2) @(posedge clock);
      for (int i = 0; i < (dataBits8 ? 8 : 7); i++) begin
         repeat (bitCycles) @(posedge clock);
         b[i] = busLine;
      end
      p = parBit(b);
      if (parityMode != RFR_PAR_NONE) begin
         repeat (bitCycles) @(posedge clock);
         p = busLine;
      end
      repeat (bitCycles) @(posedge clock);
      gotParOk <= (p === parBit(b)) && (busLine === 1'b1);
      gotByte <= b;
      gotStrobe <= 1'b1;
      @(posedge clock);
      gotStrobe <= 1'b0;
   end
endmodule : rfr_master_model

//--- test/rfr_responder_tb.sv
// self-checking bench for the rtu read responder
`timescale 1ns/1ns
module rfr_responder_tb;
   import rfr_pkg::*;
   localparam int CHAR = 88;
   // longest run is near 55000 cycles; this leaves a wide margin
   localparam int WATCHDOG = 90000;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic rxd, txd, txEnable, parityErr, crcErr, frameAccepted, gotStrobe, gotParOk;
   logic [7:0] stationAddr = 8'h01;
   logic dataBits8 = 1'b1;
   logic [7:0] gotByte;
   logic [15:0] wordAddr, wordData;
   rfr_parity_t parityMode = RFR_PAR_NONE;
   logic [7:0] expQ[$];
   int mismatches = 0;
   int samplesChecked = 0;
   int nAcc = 0, nCrc = 0, nPar = 0;
   always #5 clock = ~clock;
   // word store: a fixed pattern keyed by address
   assign wordData = wordAddr ^ 16'h5a3c;
   rfr_responder u_dut (.clock(clock), .resetn(resetn), .rxd(rxd), .txd(txd),
      .txEnable(txEnable), .stationAddr(stationAddr), .parityMode(parityMode),
      .dataBits8(dataBits8), .bitCycles(16'h0008), .wordAddr(wordAddr), .wordData(wordData),
      .parityErr(parityErr), .crcErr(crcErr), .frameAccepted(frameAccepted));
   rfr_master_model u_master (.clock(clock), .txd(txd), .txEnable(txEnable), .rxd(rxd),
      .parityMode(parityMode), .dataBits8(dataBits8), .bitCycles(16'h0008),
      .gotByte(gotByte), .gotStrobe(gotStrobe), .gotParOk(gotParOk));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction : crc16
   // status pulses are counted so each request can compare the deltas
   always @(posedge clock) begin
      nAcc <= nAcc + int'(frameAccepted);
      nCrc <= nCrc + int'(crcErr);
      nPar <= nPar + int'(parityErr);
   end
   // answer checker: each decoded byte takes the oldest note
   always @(posedge clock) if (gotStrobe) begin
      if (expQ.size() == 0) check("extra byte", 16'h1, 16'h0);
      else check("answer byte", 16'(gotByte), 16'(expQ.pop_front()));
      check("answer parity", {15'h0, gotParOk}, 16'h1);
   end
   // one request frame, its expected answer noted, then the status deltas
   task automatic request(input logic [7:0] sta, input logic [15:0] start,
      input logic [15:0] cnt, input logic [15:0] crcX, input int parBad);
      logic [7:0] f[$];
      logic [7:0] r[$];
      logic [15:0] c;
      logic ePar, eAcc;
      int a0, c0, p0;
      a0 = nAcc;
      c0 = nCrc;
      p0 = nPar;
      ePar = parBad >= 0 && parityMode != RFR_PAR_NONE;
      eAcc = crcX == 0 && !ePar && (sta == stationAddr || sta == 8'h00);
      f = {sta, 8'h03, start[15:8], start[7:0], cnt[15:8], cnt[7:0]};
      c = crc16(f) ^ crcX;
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      if (eAcc && sta != 8'h00 && cnt >= 16'h0001 && cnt <= 16'h0010) begin
         r = {stationAddr, 8'h03, 8'(cnt << 1)};
         for (int w = 0; w < int'(cnt); w++) begin
            r.push_back(8'((start + 16'(w)) >> 8) ^ 8'h5a);
            r.push_back(start[7:0] + 8'(w) ^ 8'h3c);
         end
         c = crc16(r);
         r.push_back(c[7:0]);
         r.push_back(c[15:8]);
         expQ = {expQ, r};
      end
      foreach (f[i]) u_master.sendChar(f[i], i == parBad);
      repeat (5 * CHAR) @(posedge clock);
      check("driver on", {15'h0, txEnable}, {15'h0, r.size() > 0});
      for (int n = 0; n < 40 * CHAR && txEnable; n++) @(posedge clock);
      check("driver off", {15'h0, txEnable}, 16'h0);
      check("accepted", 16'(nAcc - a0), {15'h0, eAcc});
      check("parity errors", 16'(nPar - p0), {15'h0, ePar});
      if (!ePar) check("crc errors", 16'(nCrc - c0), {15'h0, crcX != 0});
      check("leftover", 16'(expQ.size()), 16'h0);
   endtask : request
   // verdict and end of run, reached by the tests and by the watchdog alike
   task automatic finishTest();
      if (mismatches == 0 && samplesChecked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finishTest
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (WATCHDOG) @(posedge clock);
      mismatches++;
      finishTest();
   end
   // stimulus: three parity modes, then a pass with seven data bits
   initial begin
      int accBase;
      int parBase;
      void'($urandom(32'hcc13fd1c));
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         parityMode <= rfr_parity_t'(m);
         stationAddr <= 8'(1 + $urandom_range(246));
         repeat (2) @(posedge clock);
         request(stationAddr, 16'($urandom), 16'(1 + $urandom_range(15)), 16'h0, -1);
         request(stationAddr, 16'hfff8, 16'h0010, 16'h0, -1);
         request(8'h00, 16'h0004, 16'h0002, 16'h0, -1);
         request(~stationAddr, 16'h0004, 16'h0002, 16'h0, -1);
         request(stationAddr, 16'h0004, 16'h0002, 16'h0100, -1);
         request(stationAddr, 16'h0004, 16'h0002, 16'h0, 3);
         request(stationAddr, 16'h0004, 16'h0000, 16'h0, -1);
         request(stationAddr, 16'h0004, 16'h0011, 16'h0, -1);
         // partial frame, then silence past the abort gap
         u_master.sendChar(stationAddr, 1'b0);
         u_master.sendChar(8'h03, 1'b0);
         repeat (3 * CHAR) @(posedge clock);
         request(stationAddr, 16'h0100, 16'h0001, 16'h0, -1);
      end
      // seven data bits: parity covers bits 6:0, the short frame is dropped
      dataBits8 <= 1'b0;
      parityMode <= RFR_PAR_EVEN;
      repeat (2) @(posedge clock);
      accBase = nAcc;
      parBase = nPar;
      u_master.sendChar(8'h43, 1'b0);
      u_master.sendChar(8'h41, 1'b1);
      repeat (3 * CHAR) @(posedge clock);
      check("parity errors 7 bit", 16'(nPar - parBase), 16'h1);
      check("accepted 7 bit", 16'(nAcc - accBase), 16'h0);
      finishTest();
   end
endmodule : rfr_responder_tb
